// >>> ppc_pkg.sv
// Constants shared by the port pin cell configuration block
package ppc_pkg;
   // ==========================================================
   // Sizes
   localparam int N_PINS = 17;
   localparam int N_XB = 16;
   localparam int N_RES = 4;
   localparam int RES_W = 2;
   localparam int ADDR_W = 8;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_LATCH = 8'h00;
   localparam logic [7:0] OFS_MODE_IN = 8'h04;
   localparam logic [7:0] OFS_MODE_OUT = 8'h08;
   localparam logic [7:0] OFS_SKIP = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_XSEL = 8'h14;
   // ==========================================================
   // Fields and reset values
   localparam int CTRL_XBAR_BIT = 0;
   localparam int CTRL_PUD_BIT = 1;
   localparam logic [16:0] RST_LATCH = 17'h1FFFF;
   localparam logic [15:0] RST_MODE_IN = 16'hFFFF;
   localparam logic [16:0] RST_MODE_OUT = 17'h00000;
   localparam logic [15:0] RST_SKIP = 16'h0000;
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [3:0] RST_XSEL = 4'h0;
   localparam logic [16:0] RST_LEVEL = 17'h1FFFF;
   // ==========================================================
   // Fixed pin positions
   localparam int PIN_VREF = 0;
   localparam int PIN_ANALOG_GROUND_PIN = 1;
   localparam int PIN_OSC_IN = 2;
   localparam int PIN_OSC_OUT = 3;
   localparam int PIN_DEBUG = 16;
   // ==========================================================
   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// >>> ppc_sync_if.sv
// Raw pad levels in, filtered levels out
`timescale 1ns/100ps
interface ppc_sync_if;
   import ppc_pkg::*;
   logic [N_PINS-1:0] raw;
   logic [N_PINS-1:0] level;
   modport filt (input raw, output level);
   modport user (output raw, input level);
endinterface

// >>> ppc_sync.sv
// Three-stage pad input synchroniser with agreement filter
`timescale 1ns/100ps
module ppc_sync
   import ppc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   ppc_sync_if.filt sif
);
   logic [N_PINS-1:0] s1_q;
   logic [N_PINS-1:0] s2_q;
   logic [N_PINS-1:0] s3_q;
   logic [N_PINS-1:0] lvl_q;
   logic [N_PINS-1:0] lvl_d;

   // ==========================================================
   // Stages
   // A level only moves once stages two and three agree
   assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
   assign sif.level = lvl_q;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_q <= RST_LEVEL;
         s2_q <= RST_LEVEL;
         s3_q <= RST_LEVEL;
         lvl_q <= RST_LEVEL;
      end
      else if (clk_en)
      begin
         s1_q <= sif.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end
endmodule

// >>> ppc_port.sv
// Port pin cells, crossbar placement and AHB-Lite register slave
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
// Contract
// - latch read returns present pin state
// - reset leaves cells high-Z, pull-ups on
// - crossbar disabled keeps crossbar pin drivers off
// - analog pin drops pull-up, driver, receiver
// - analog pin reads back zero
// - push-pull drives pad fully high or low
// - open-drain never drives high
// - pull-up on when high-Z, off driving low
// - global disable kills every pull-up
// - digital pin reads pad level, not output
// - reserved pin never gets crossbar resource
// - first sixteen pins analog, peripheral or interrupt
// - last pin digital only, debug data shared
// - fixed pins for reference, ground, oscillator
// - crossbar takes least-significant free unreserved pin
module ppc_port
   import ppc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [N_PINS-1:0] pad_in,
   output logic [N_PINS-1:0] pad_out,
   output logic [N_PINS-1:0] pad_oe_n,
   output logic [N_PINS-1:0] pad_pu_en,
   input wire logic [N_RES-1:0] res_out,
   output logic [N_RES-1:0] res_in,
   output logic [N_PINS-1:0] pin_in_level,
   output logic [N_XB-1:0] analog_conn,
   output logic voltage_reference_pin,
   output logic analog_ground_pin,
   output logic oscillator_input_pin,
   output logic oscillator_output_pin,
   output logic debug_data_pin
);
   // ==========================================================
   // Registers
   logic [N_PINS-1:0] pin_latch_bit_q;
   logic [N_XB-1:0] pin_input_mode_bit_q;
   logic [N_PINS-1:0] pin_output_drive_select_q;
   logic [N_XB-1:0] crossbar_reserve_bit_q;
   logic [1:0] ctrl_q;
   logic [N_RES-1:0] crossbar_select_first_q;
   logic wr_pend_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_d;
   logic [N_PINS-1:0] out_q;
   logic [N_PINS-1:0] oe_n_q;
   logic [N_PINS-1:0] pu_q;
   logic [N_PINS-1:0] out_d;
   logic [N_PINS-1:0] oe_n_d;
   logic [N_PINS-1:0] pu_d;

   // ==========================================================
   // Decode
   wire crossbar_global_enable = ctrl_q[CTRL_XBAR_BIT];
   wire global_pullup_disable = ctrl_q[CTRL_PUD_BIT];
   wire acc = hsel & hready & htrans[1] & clk_en;
   wire acc_wr = acc & hwrite;
   wire acc_rd = acc & ~hwrite;
   wire do_wr = wr_pend_q & clk_en;
   wire wr_latch = do_wr & (wr_addr_q == OFS_LATCH);
   wire wr_min = do_wr & (wr_addr_q == OFS_MODE_IN);
   wire wr_mout = do_wr & (wr_addr_q == OFS_MODE_OUT);
   wire wr_skip = do_wr & (wr_addr_q == OFS_SKIP);
   wire wr_ctrl = do_wr & (wr_addr_q == OFS_CTRL);
   wire wr_xsel = do_wr & (wr_addr_q == OFS_XSEL);
   wire [N_PINS-1:0] digital = {1'b1, pin_input_mode_bit_q};
   wire [N_PINS-1:0] rd_level;
   logic [N_PINS-1:0] cell_val;
   logic [N_PINS-1:0] own_vld;
   logic [RES_W-1:0] own_idx [N_PINS];

   assign hreadyout = clk_en;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign pad_out = out_q;
   assign pad_oe_n = oe_n_q;
   assign pad_pu_en = pu_q;

   // ==========================================================
   // Pad input synchroniser
   ppc_sync_if sif ();
   assign sif.raw = pad_in;

   ppc_sync u_sync
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .sif(sif.filt)
   );

   // Receiver off on analog pins, so they read zero
   assign rd_level = sif.level & digital;
   assign pin_in_level = rd_level;
   assign analog_conn = ~pin_input_mode_bit_q;
   assign debug_data_pin = rd_level[PIN_DEBUG];

   // Analog functions on fixed pads, only when analog and reserved
   assign voltage_reference_pin = analog_conn[PIN_VREF] &
      crossbar_reserve_bit_q[PIN_VREF];
   assign analog_ground_pin = analog_conn[PIN_ANALOG_GROUND_PIN] &
      crossbar_reserve_bit_q[PIN_ANALOG_GROUND_PIN];
   assign oscillator_input_pin = analog_conn[PIN_OSC_IN] &
      crossbar_reserve_bit_q[PIN_OSC_IN];
   assign oscillator_output_pin = analog_conn[PIN_OSC_OUT] &
      crossbar_reserve_bit_q[PIN_OSC_OUT];

   // ==========================================================
   // Crossbar placement
   // Priority by resource index; reserved pins count as taken
   always_comb
   begin
      logic [N_XB-1:0] taken;
      logic found;
      taken = crossbar_reserve_bit_q;
      found = 1'b0;
      own_vld = '0;
      for (int p = 0; p < N_PINS; p++)
         own_idx[p] = '0;
      for (int r = 0; r < N_RES; r++)
      begin
         found = 1'b0;
         if (crossbar_select_first_q[r])
         begin
            for (int p = 0; p < N_XB; p++)
            begin
               if (!found && !taken[p])
               begin
                  taken[p] = 1'b1;
                  own_vld[p] = 1'b1;
                  own_idx[p] = RES_W'(r);
                  found = 1'b1;
               end
            end
         end
      end
   end

   always_comb
   begin
      res_in = '0;
      for (int p = 0; p < N_XB; p++)
         if (own_vld[p])
            res_in[own_idx[p]] = rd_level[p];
   end

   // ==========================================================
   // Pin cells
   genvar i;
   generate
      for (i = 0; i < N_PINS; i++)
      begin : g_cell
         wire xb_pin = (i != PIN_DEBUG);
         wire en = ~xb_pin | crossbar_global_enable;
         wire pp = pin_output_drive_select_q[i];
         wire drv_lo;
         wire drv_hi;
         assign cell_val[i] = own_vld[i] ? res_out[own_idx[i]] :
            pin_latch_bit_q[i];
         assign drv_lo = en & digital[i] & ~cell_val[i];
         assign drv_hi = en & digital[i] & pp & cell_val[i];
         assign oe_n_d[i] = ~(drv_lo | drv_hi);
         assign out_d[i] = cell_val[i] & drv_hi;
         // Pull-up only on a digital cell not pulling low
         assign pu_d[i] = digital[i] & ~drv_lo &
            ~global_pullup_disable;
      end
   endgenerate

   // Cell controls registered so pads never see decode glitches
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         out_q <= '0;
         oe_n_q <= '1;
         pu_q <= '1;
      end
      else if (clk_en)
      begin
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         pu_q <= pu_d;
      end
   end

   // ==========================================================
   // Bus slave
   always_comb
   begin
      rd_d = '0;
      case (haddr)
         OFS_LATCH: rd_d[N_PINS-1:0] = rd_level;
         OFS_MODE_IN: rd_d[N_XB-1:0] = pin_input_mode_bit_q;
         OFS_MODE_OUT: rd_d[N_PINS-1:0] = pin_output_drive_select_q;
         OFS_SKIP: rd_d[N_XB-1:0] = crossbar_reserve_bit_q;
         OFS_CTRL: rd_d[1:0] = ctrl_q;
         OFS_XSEL: rd_d[N_RES-1:0] = crossbar_select_first_q;
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         hrdata_q <= '0;
      end
      else if (clk_en)
      begin
         wr_pend_q <= acc_wr;
         if (acc_wr)
            wr_addr_q <= haddr;
         if (acc_rd)
            hrdata_q <= rd_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_latch_bit_q <= RST_LATCH;
         pin_input_mode_bit_q <= RST_MODE_IN;
         pin_output_drive_select_q <= RST_MODE_OUT;
         crossbar_reserve_bit_q <= RST_SKIP;
         ctrl_q <= RST_CTRL;
         crossbar_select_first_q <= RST_XSEL;
      end
      else
      begin
         if (wr_latch)
            pin_latch_bit_q <= hwdata[N_PINS-1:0];
         if (wr_min)
            pin_input_mode_bit_q <= hwdata[N_XB-1:0];
         if (wr_mout)
            pin_output_drive_select_q <= hwdata[N_PINS-1:0];
         if (wr_skip)
            crossbar_reserve_bit_q <= hwdata[N_XB-1:0];
         if (wr_ctrl)
            ctrl_q <= hwdata[1:0];
         if (wr_xsel)
            crossbar_select_first_q <= hwdata[N_RES-1:0];
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   logic started_q;
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         started_q <= 1'b0;
      else if (clk_en)
         started_q <= 1'b1;
   end

   wire [N_XB-1:0] pp_dig = pin_input_mode_bit_q &
      pin_output_drive_select_q[N_XB-1:0];
   wire [N_XB-1:0] od_high = ~pin_output_drive_select_q[N_XB-1:0] &
      cell_val[N_XB-1:0];

   sequence s_latch_rd;
      acc_rd && haddr == OFS_LATCH;
   endsequence

   latch_read_a: assert property (
      s_latch_rd |=> hrdata[N_PINS-1:0] == $past(rd_level))
      else $error("latch read does not show pin state");

   reset_cells_a: assert property (
      !started_q |-> (&pad_oe_n && &pad_pu_en))
      else $error("cells not high-Z with pull-up after reset");

   xbar_off_a: assert property (
      clk_en && !crossbar_global_enable |=> &pad_oe_n[N_XB-1:0])
      else $error("crossbar pin driven while crossbar off");

   analog_cell_a: assert property (
      clk_en |=> ((pad_pu_en[N_XB-1:0] | ~pad_oe_n[N_XB-1:0]) &
      ~$past(pin_input_mode_bit_q)) == '0)
      else $error("analog pin still has pull-up or driver");

   analog_read_a: assert property (
      s_latch_rd |=> (hrdata[N_XB-1:0] & ~$past(pin_input_mode_bit_q))
      == '0)
      else $error("analog pin read back nonzero");

   push_pull_a: assert property (
      clk_en && crossbar_global_enable |=>
      (pad_oe_n[N_XB-1:0] & $past(pp_dig)) == '0 &&
      (pad_out[N_XB-1:0] & $past(pp_dig)) ==
      ($past(cell_val[N_XB-1:0]) & $past(pp_dig)))
      else $error("push-pull pin not driven to its value");

   open_drain_a: assert property (
      clk_en |=> (~pad_oe_n[N_XB-1:0] & $past(od_high)) == '0)
      else $error("open-drain pin driven while value is one");

   pullup_low_a: assert property (
      (pad_pu_en & ~pad_oe_n & ~pad_out) == '0)
      else $error("pull-up on while driving low");

   pullup_off_a: assert property (
      clk_en && global_pullup_disable |=> pad_pu_en == '0)
      else $error("pull-up on while globally disabled");

   skip_pin_a: assert property (
      ((own_vld[N_XB-1:0] | (cell_val[N_XB-1:0] ^
      pin_latch_bit_q[N_XB-1:0])) & crossbar_reserve_bit_q) == '0)
      else $error("reserved pin given a crossbar resource");

   debug_pin_a: assert property (
      clk_en && pin_output_drive_select_q[PIN_DEBUG] |=>
      !pad_oe_n[PIN_DEBUG] &&
      pad_out[PIN_DEBUG] == $past(pin_latch_bit_q[PIN_DEBUG]))
      else $error("last pin not driven as plain digital");
endmodule

// >>> ppc_pad_model.sv
// Pad-side circuitry: external drivers, pull-ups and floating pads
`timescale 1ns/100ps
module ppc_pad_model
   import ppc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [N_PINS-1:0] pad_out,
   input wire logic [N_PINS-1:0] pad_oe_n,
   input wire logic [N_PINS-1:0] pad_pu_en,
   input wire logic [N_PINS-1:0] ext_en,
   input wire logic [N_PINS-1:0] ext_val,
   output logic [N_PINS-1:0] pad_in
);
   // ==========================================================
   // Pad resolution
   logic [N_PINS-1:0] float_q = '0;
   wire logic [N_PINS-1:0] released = pad_oe_n & ~ext_en;
   // Undriven pads without pull-up toggle so a stale level can never pass
   always_ff @(posedge ref_clk)
   begin
      float_q <= ~float_q;
   end
   assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
      | (released & pad_pu_en) | (released & ~pad_pu_en & float_q);
endmodule

// >>> testbench.sv
// Self-checking bench for the port pin cell block
`timescale 1ns/100ps
module testbench;
   import ppc_pkg::*;
   // ==========================================================
   // Signals
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic clk_en = 1'b1;
   logic hsel = 1'b0;
   logic [ADDR_W-1:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = '0;
   logic [N_RES-1:0] res_out = '0;
   logic [N_PINS-1:0] ext_en = '0;
   logic [N_PINS-1:0] ext_val = '0;
   logic hreadyout, hresp, vref_o, analog_ground_pin_o, osc_i, osc_o, dbg_o;
   logic [31:0] hrdata;
   logic [N_PINS-1:0] pad_in, pad_out, pad_oe_n, pad_pu_en, pin_in_level;
   logic [N_RES-1:0] res_in;
   logic [N_XB-1:0] analog_conn;
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #5 ref_clk = ~ref_clk;
   // ==========================================================
   // Design and pads
   ppc_port i_dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pu_en(pad_pu_en), .res_out(res_out), .res_in(res_in),
      .pin_in_level(pin_in_level), .analog_conn(analog_conn),
      .voltage_reference_pin(vref_o), .analog_ground_pin(analog_ground_pin_o),
      .oscillator_input_pin(osc_i), .oscillator_output_pin(osc_o),
      .debug_data_pin(dbg_o));
   ppc_pad_model i_pads (.ref_clk(ref_clk), .pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .pad_pu_en(pad_pu_en), .ext_en(ext_en),
      .ext_val(ext_val), .pad_in(pad_in));
   // ==========================================================
   // Tasks
   task automatic tally_and_finish();
      if (err_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Settle past the edge so registered outputs are stable
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   // ==========================================================
   // Timeout, far beyond the expected run of under two hundred cycles
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   // ==========================================================
   // Sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      tick(1);
      chk(pad_oe_n, 32'h1FFFF);
      chk(pad_pu_en, 32'h1FFFF);
      chk(hresp, 32'h0);
      chk(dbg_o, 32'h1);
      tick(8);
      rd(OFS_LATCH, 32'h1FFFF);
      rd(OFS_MODE_IN, 32'hFFFF);
      rd(OFS_MODE_OUT, 32'h0);
      rd(OFS_SKIP, 32'h0);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_XSEL, 32'h0);
      rd(8'h18, 32'h0);
      // Push-pull low with the crossbar still off
      wr(OFS_MODE_OUT, 32'h1FFFF);
      wr(OFS_LATCH, 32'h0);
      tick(2);
      chk(pad_oe_n, 32'h0FFFF);
      chk(pad_out[PIN_DEBUG], 32'h0);
      wr(OFS_CTRL, 32'h1);
      tick(2);
      chk(pad_oe_n, 32'h0);
      chk(pad_out, 32'h0);
      chk(pad_pu_en, 32'h0);
      tick(8);
      chk(dbg_o, 32'h0);
      rd(OFS_LATCH, 32'h0);
      wr(OFS_LATCH, 32'h1FFFF);
      tick(2);
      chk(pad_out, 32'h1FFFF);
      chk(pad_oe_n, 32'h0);
      // Open-drain, one pad pulled low from outside
      wr(OFS_MODE_OUT, 32'h0);
      tick(2);
      chk(pad_oe_n, 32'h1FFFF);
      chk(pad_pu_en, 32'h1FFFF);
      ext_en <= 17'h00020;
      tick(2);
      chk(pin_in_level[5], 32'h1);
      tick(8);
      rd(OFS_LATCH, 32'h1FFDF);
      ext_en <= 17'h0;
      wr(OFS_LATCH, 32'h1FFFE);
      tick(2);
      chk(pad_oe_n, 32'h1FFFE);
      chk(pad_out[0], 32'h0);
      chk(pad_pu_en, 32'h1FFFE);
      wr(OFS_CTRL, 32'h3);
      tick(2);
      chk(pad_pu_en, 32'h0);
      // Analog on the four fixed pins
      wr(OFS_CTRL, 32'h1);
      wr(OFS_LATCH, 32'h1FFFF);
      wr(OFS_SKIP, 32'h000F);
      wr(OFS_MODE_IN, 32'hFFF0);
      tick(2);
      chk(analog_conn, 32'h000F);
      chk(pad_pu_en, 32'h1FFF0);
      chk(pad_oe_n, 32'h1FFFF);
      chk({vref_o, analog_ground_pin_o, osc_i, osc_o}, 32'hF);
      tick(8);
      rd(OFS_LATCH, 32'h1FFF0);
      chk(pin_in_level[3:0], 32'h0);
      // Crossbar placement around reserved pins
      wr(OFS_MODE_IN, 32'hFFFF);
      wr(OFS_MODE_OUT, 32'h1FFFF);
      wr(OFS_SKIP, 32'h0003);
      wr(OFS_XSEL, 32'h3);
      res_out <= 4'h1;
      tick(3);
      chk(pad_out, 32'h1FFF7);
      @(posedge ref_clk);
      res_out <= 4'h2;
      tick(3);
      chk(pad_out, 32'h1FFFB);
      tick(8);
      chk(res_in, 32'h2);
      wr(OFS_XSEL, 32'hF);
      res_out <= 4'h5;
      tick(3);
      chk(pad_out, 32'h1FFD7);
      // Clock enable low: bus stalls and pads hold their state
      @(posedge ref_clk);
      clk_en <= 1'b0;
      res_out <= 4'h0;
      tick(3);
      chk(hreadyout, 32'h0);
      chk(pad_out, 32'h1FFD7);
      fork
         rd(OFS_XSEL, 32'hF);
         begin
            repeat (3) @(posedge ref_clk);
            clk_en <= 1'b1;
         end
      join
      tick(2);
      chk(pad_out, 32'h1FFC3);
      tally_and_finish();
   end
endmodule
